// file: logic/pis_regs.svh
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH

// Register set geometry
`define PIS_NUM_REGS    8
`define PIS_IDX_W       3
`define PIS_PI_W        64
`define PIS_FP_W        80
`define PIS_VEC_W       128
`define PIS_ADDR_W      32

// Alignment and cache geometry, in bytes
`define PIS_PI_ALIGN    8
`define PIS_VEC_ALIGN   16
`define PIS_LINE_BYTES  64

// Extra cycles, counted at the core clock
`define PIS_SWITCH_CYC  3'h2
`define PIS_SPLIT_CYC   3'h1
`define PIS_UNALIGN_CYC 3'h1

// Reset and fill values
`define PIS_MM_UPPER    16'hffff
`define PIS_TAG_FULL    8'hff
`define PIS_TAG_EMPTY   8'h00
`define PIS_TOP_RST     3'h0

`endif

// file: logic/pis_pkg.sv
`include "pis_regs.svh"
`default_nettype none

package pis_pkg;

  typedef enum logic [3:0] {
    PIS_PI_WR,
    PIS_PI_RD,
    PIS_PI_LD,
    PIS_FP_PUSH,
    PIS_FP_POP,
    PIS_FP_RD,
    PIS_EMPTY,
    PIS_VEC_WR,
    PIS_VEC_RD,
    PIS_VEC_LD,
    PIS_UDQ_LD
  } pis_op_t;

  typedef struct packed {
    pis_op_t                 op;
    logic [`PIS_IDX_W-1:0]   idx;
    logic [`PIS_ADDR_W-1:0]  addr;
    logic [`PIS_VEC_W-1:0]   wdata;
  } pis_req_t;

  typedef struct packed {
    logic [`PIS_VEC_W-1:0]   rdata;
    logic                    stack_fault;
    logic                    align_fault;
  } pis_resp_t;

  typedef struct packed {
    logic [`PIS_NUM_REGS-1:0][`PIS_FP_W-1:0]  phys;
    logic [`PIS_NUM_REGS-1:0][`PIS_VEC_W-1:0] vec;
    logic [`PIS_NUM_REGS-1:0]                 tag;
    logic [`PIS_IDX_W-1:0]                    top;
    logic                                     last_pi;
    logic [2:0]                               cnt;
    logic                                     ready;
    logic                                     resp_valid;
    pis_resp_t                                resp;
    pis_resp_t                                pend;
  } pis_state_t;

endpackage

`default_nettype wire

// file: logic/pis_align_check.sv
`include "pis_regs.svh"
`default_nettype none

module pis_align_check (
  // Memory reference
  input  wire pis_pkg::pis_op_t       op,
  input  wire logic [`PIS_ADDR_W-1:0] addr,
  // Verdict
  output logic                        align_fault,
  output logic [2:0]                  extra_cyc
);

  logic [5:0] line_off;

  always_comb begin
    line_off    = addr[5:0];
    align_fault = 1'b0;
    extra_cyc   = 3'h0;
    unique case (op)
      pis_pkg::PIS_PI_LD: begin
        if (line_off > 6'(`PIS_LINE_BYTES - `PIS_PI_ALIGN)) begin
          extra_cyc = `PIS_SPLIT_CYC;
        end
      end
      pis_pkg::PIS_VEC_LD: begin
        align_fault = (addr[3:0] != 4'h0);
      end
      pis_pkg::PIS_UDQ_LD: begin
        if (addr[3:0] != 4'h0) begin
          extra_cyc = `PIS_UNALIGN_CYC;
        end
      end
      default: begin
        extra_cyc = 3'h0;
      end
    endcase
  end

endmodule

`default_nettype wire

// file: logic/pis_shared_regs.sv
// Functional notes
// - The eight 64-bit packed-integer registers live in the same storage as the float stack registers.
// - Any packed-integer register reference sets every valid bit of the float tag word.
// - The empty-state operation clears every valid bit of the float tag word.
// - 128-bit vector operands live in a separate register set and never touch the tag word.
// - A float push onto a stack whose tags are all valid raises a stack overflow fault.
// - A misaligned 128-bit vector load faults unless it is the unaligned double-quadword move.
// - A misaligned 64-bit packed-integer load never faults, though a line split costs extra cycles.
// - Switching from packed-integer to float work costs a few cycles but stays correct.
// - The unaligned double-quadword move may be slower but returns the same bytes.
`include "pis_regs.svh"
`default_nettype none

module pis_shared_regs (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Request
  input  wire logic                        req_valid,
  input  wire pis_pkg::pis_req_t           req,
  output logic                             req_ready,
  // Answer
  output logic                             resp_valid,
  output pis_pkg::pis_resp_t               resp,
  // Observed stack state
  output logic [`PIS_NUM_REGS-1:0]         tag_word,
  output logic [`PIS_IDX_W-1:0]            stack_top
);

  pis_pkg::pis_state_t state_reg;
  pis_pkg::pis_state_t state_next;
  logic                acc;
  logic                mem_fault;
  logic [2:0]          mem_extra;
  logic [2:0]          extra;
  logic [`PIS_IDX_W-1:0] slot;
  pis_pkg::pis_resp_t  ans;

  function automatic logic is_pi(input pis_pkg::pis_op_t op);
    return op inside {pis_pkg::PIS_PI_WR, pis_pkg::PIS_PI_RD, pis_pkg::PIS_PI_LD};
  endfunction

  function automatic logic is_fp(input pis_pkg::pis_op_t op);
    return op inside {pis_pkg::PIS_FP_PUSH, pis_pkg::PIS_FP_POP, pis_pkg::PIS_FP_RD};
  endfunction

  function automatic logic is_vec(input pis_pkg::pis_op_t op);
    return op inside {pis_pkg::PIS_VEC_WR, pis_pkg::PIS_VEC_RD, pis_pkg::PIS_VEC_LD, pis_pkg::PIS_UDQ_LD};
  endfunction

  assign acc = req_valid && state_reg.ready;

  pis_align_check u_align (
    .op          (req.op),
    .addr        (req.addr),
    .align_fault (mem_fault),
    .extra_cyc   (mem_extra)
  );

  always_comb begin
    state_next            = state_reg;
    state_next.resp_valid = 1'b0;
    extra                 = 3'h0;
    slot                  = '0;
    ans                   = '0;
    if (state_reg.cnt != 3'h0) begin
      state_next.cnt = state_reg.cnt - 3'h1;
      if (state_reg.cnt == 3'h1) begin
        state_next.resp_valid = 1'b1;
        state_next.resp       = state_reg.pend;
        state_next.ready      = 1'b1;
      end
    end else if (acc) begin
      extra = mem_extra;
      if (is_pi(req.op)) begin
        state_next.tag     = `PIS_TAG_FULL;
        state_next.top     = `PIS_TOP_RST;
        state_next.last_pi = 1'b1;
      end
      if (is_fp(req.op) && state_reg.last_pi) begin
        extra              = 3'(mem_extra + `PIS_SWITCH_CYC);
        state_next.last_pi = 1'b0;
      end else if (is_fp(req.op)) begin
        state_next.last_pi = 1'b0;
      end
      unique case (req.op)
        // low 64 bits, upper field all ones
        pis_pkg::PIS_PI_WR, pis_pkg::PIS_PI_LD: begin
          state_next.phys[req.idx] = {`PIS_MM_UPPER, req.wdata[`PIS_PI_W-1:0]};
        end
        pis_pkg::PIS_PI_RD: begin
          ans.rdata = {64'h0, state_reg.phys[req.idx][`PIS_PI_W-1:0]};
        end
        pis_pkg::PIS_FP_PUSH: begin
          slot = state_reg.top - 3'h1;
          if (state_reg.tag[slot]) begin
            ans.stack_fault = 1'b1;
          end else begin
            state_next.phys[slot] = req.wdata[`PIS_FP_W-1:0];
            state_next.tag[slot]  = 1'b1;
            state_next.top        = slot;
          end
        end
        pis_pkg::PIS_FP_POP: begin
          slot = state_reg.top;
          if (!state_reg.tag[slot]) begin
            ans.stack_fault = 1'b1;
          end else begin
            ans.rdata            = {48'h0, state_reg.phys[slot]};
            state_next.tag[slot] = 1'b0;
            state_next.top       = slot + 3'h1;
          end
        end
        pis_pkg::PIS_FP_RD: begin
          slot      = state_reg.top + req.idx;
          ans.rdata = {48'h0, state_reg.phys[slot]};
        end
        pis_pkg::PIS_EMPTY: begin
          state_next.tag = `PIS_TAG_EMPTY;
        end
        pis_pkg::PIS_VEC_WR, pis_pkg::PIS_UDQ_LD: begin
          state_next.vec[req.idx] = req.wdata;
        end
        pis_pkg::PIS_VEC_RD: begin
          ans.rdata = state_reg.vec[req.idx];
        end
        pis_pkg::PIS_VEC_LD: begin
          ans.align_fault = mem_fault;
          if (!mem_fault) begin
            state_next.vec[req.idx] = req.wdata;
          end
        end
        // Unused op codes do nothing
        default: begin
          ans = '0;
        end
      endcase
      if (extra == 3'h0) begin
        state_next.resp_valid = 1'b1;
        state_next.resp       = ans;
      end else begin
        state_next.cnt   = extra;
        state_next.pend  = ans;
        state_next.ready = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg       <= '0;
      state_reg.ready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign req_ready  = state_reg.ready;
  assign resp_valid = state_reg.resp_valid;
  assign resp       = state_reg.resp;
  assign tag_word   = state_reg.tag;
  assign stack_top  = state_reg.top;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_pi_sets_tags;
    acc && is_pi(req.op) |=> tag_word == `PIS_TAG_FULL;
  endproperty
  a_pi_sets_tags: assert property (p_pi_sets_tags) else $error("tags not set by packed-int use");

  property p_empty_clears;
    acc && req.op == pis_pkg::PIS_EMPTY |=> tag_word == `PIS_TAG_EMPTY;
  endproperty
  a_empty_clears: assert property (p_empty_clears) else $error("tags not cleared by empty");

  property p_vec_keeps_tag;
    acc && is_vec(req.op) |=> $stable(tag_word);
  endproperty
  a_vec_keeps_tag: assert property (p_vec_keeps_tag) else $error("vector op changed tags");

  property p_push_ovf;
    acc && req.op == pis_pkg::PIS_FP_PUSH && tag_word == `PIS_TAG_FULL
      |-> ##[1:3] resp_valid && resp.stack_fault;
  endproperty
  a_push_ovf: assert property (p_push_ovf) else $error("no overflow on full stack push");

  property p_vec_misalign;
    acc && req.op == pis_pkg::PIS_VEC_LD && req.addr[3:0] != 4'h0 |=> resp_valid && resp.align_fault;
  endproperty
  a_vec_misalign: assert property (p_vec_misalign) else $error("misaligned vector load passed");

  property p_udq_ok;
    acc && req.op == pis_pkg::PIS_UDQ_LD && req.addr[3:0] != 4'h0
      |=> !resp_valid ##1 resp_valid && !resp.align_fault;
  endproperty
  a_udq_ok: assert property (p_udq_ok) else $error("unaligned move wrong timing or fault");

  property p_pi_ld_ok;
    acc && req.op == pis_pkg::PIS_PI_LD |-> ##[1:2] resp_valid && !resp.align_fault;
  endproperty
  a_pi_ld_ok: assert property (p_pi_ld_ok) else $error("packed-int load faulted or late");

  property p_alias;
    acc && req.op == pis_pkg::PIS_PI_WR
      |=> state_reg.phys[$past(req.idx)] == {`PIS_MM_UPPER, $past(req.wdata[`PIS_PI_W-1:0])};
  endproperty
  a_alias: assert property (p_alias) else $error("packed-int write not in shared storage");

  property p_switch;
    acc && is_fp(req.op) && state_reg.last_pi |=> !req_ready [*2] ##1 req_ready && resp_valid;
  endproperty
  a_switch: assert property (p_switch) else $error("switch penalty wrong");

  c_pi_then_empty: cover property (acc && is_pi(req.op) ##[1:5] acc && req.op == pis_pkg::PIS_EMPTY);
  c_overflow:      cover property (resp_valid && resp.stack_fault);
  c_vec_fault:     cover property (resp_valid && resp.align_fault);
  c_switch:        cover property (acc && is_fp(req.op) && state_reg.last_pi);

endmodule

`default_nettype wire

// file: dv/pis_shared_regs_tb.sv
`default_nettype none

module pis_shared_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               mclk;
  logic               rst;
  logic               req_valid;
  pis_pkg::pis_req_t  req;
  logic               req_ready;
  logic               resp_valid;
  pis_pkg::pis_resp_t resp;
  logic [7:0]         tag_word;
  logic [2:0]         stack_top;
  int                 n_fail;
  int                 compares;
  int                 cyc;
  int                 lat;
  logic [127:0]       d;
  logic [127:0]       d2;
  logic [31:0]        a;
  logic [2:0]         ix;

  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end

  pis_shared_regs u_dut (
    .mclk       (mclk),
    .rst        (rst),
    .req_valid  (req_valid),
    .req        (req),
    .req_ready  (req_ready),
    .resp_valid (resp_valid),
    .resp       (resp),
    .tag_word   (tag_word),
    .stack_top  (stack_top)
  );

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      stop_test();
    end
  end

  // Called at a falling edge; returns one falling edge after the answer
  task automatic issue(input pis_pkg::pis_op_t op, input logic [2:0] i, input logic [31:0] ad,
                       input logic [127:0] wd);
    req_valid = 1'h1;
    req.op    = op;
    req.idx   = i;
    req.addr  = ad;
    req.wdata = wd;
    @(negedge mclk);
    req_valid = 1'h0;
    lat = 1;
    // Answer pulse may already stand one cycle after the take
    while (resp_valid !== 1'h1 && lat < 8) begin
      @(negedge mclk);
      lat++;
    end
    `CHK("resp_valid", 1'h1, resp_valid)
    `CHK("ready", 1'h1, req_ready)
    // Idle cycle so valid never toggles twice in one step
    @(negedge mclk);
  endtask

  initial begin
    void'($urandom(96426));
    rst = 1'h1;
    req_valid = 1'h0;
    req = '0;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(negedge mclk);
    rst = 1'h0;
    @(negedge mclk);
    `CHK("tag rst", 8'h00, tag_word)
    `CHK("top rst", 3'h0, stack_top)
    `CHK("resp_valid rst", 1'h0, resp_valid)

    // Vector traffic leaves tags alone, packed-integer traffic fills them
    repeat (6) begin
      ix = 3'($urandom);
      d = {$urandom, $urandom, $urandom, $urandom};
      issue(pis_pkg::PIS_EMPTY, 3'h0, 32'h0, 128'h0);
      `CHK("tag empty", 8'h00, tag_word)
      issue(pis_pkg::PIS_VEC_WR, ix, 32'h0, ~d);
      issue(pis_pkg::PIS_VEC_RD, ix, 32'h0, 128'h0);
      `CHK("vec rdata", ~d, resp.rdata)
      `CHK("tag vec", 8'h00, tag_word)
      issue(pis_pkg::PIS_PI_WR, ix, 32'h0, d);
      `CHK("tag pi", 8'hff, tag_word)
      `CHK("pi lat", 1, lat)
      issue(pis_pkg::PIS_PI_RD, ix, 32'h0, 128'h0);
      `CHK("pi rdata", {64'h0, d[63:0]}, resp.rdata)
    end
    $display("test alias done");

    // Push straight after packed-integer use overflows after the switch delay
    issue(pis_pkg::PIS_FP_PUSH, 3'h0, 32'h0, d);
    `CHK("push lat", 3, lat)
    `CHK("push fault", 1'h1, resp.stack_fault)
    `CHK("tag push", 8'hff, tag_word)
    issue(pis_pkg::PIS_PI_WR, 3'h0, 32'h0, d);
    issue(pis_pkg::PIS_FP_POP, 3'h0, 32'h0, 128'h0);
    `CHK("pop lat", 3, lat)
    `CHK("pop fault", 1'h0, resp.stack_fault)
    `CHK("pop data", {16'hffff, d[63:0]}, resp.rdata[79:0])
    d2 = {$urandom, $urandom, $urandom, $urandom};
    issue(pis_pkg::PIS_EMPTY, 3'h0, 32'h0, 128'h0);
    // Pop left top at 1; empty keeps top, so the push lands in slot 0
    issue(pis_pkg::PIS_FP_PUSH, 3'h0, 32'h0, d2);
    `CHK("push ok", 1'h0, resp.stack_fault)
    `CHK("top push", 3'h0, stack_top)
    issue(pis_pkg::PIS_FP_RD, 3'h0, 32'h0, 128'h0);
    `CHK("fp rd", d2[79:0], resp.rdata[79:0])
    issue(pis_pkg::PIS_PI_RD, 3'h0, 32'h0, 128'h0);
    `CHK("pi view", {64'h0, d2[63:0]}, resp.rdata)
    `CHK("tag ref", 8'hff, tag_word)
    $display("test switch done");

    // Every low-nibble offset for vector loads
    for (int k = 0; k < 16; k++) begin
      a = $urandom;
      a[3:0] = 4'(k);
      d = {$urandom, $urandom, $urandom, $urandom};
      issue(pis_pkg::PIS_VEC_LD, 3'h1, a, d);
      `CHK("vec fault", (k != 0), resp.align_fault)
      issue(pis_pkg::PIS_UDQ_LD, 3'h2, a, d);
      `CHK("udq fault", 1'h0, resp.align_fault)
      `CHK("udq lat", (k != 0) ? 2 : 1, lat)
      issue(pis_pkg::PIS_VEC_RD, 3'h2, 32'h0, 128'h0);
      `CHK("udq data", d, resp.rdata)
    end
    $display("test vec align done");

    // Offsets past 56 split a 64-byte line
    for (int k = 48; k < 64; k++) begin
      a = $urandom;
      a[5:0] = 6'(k);
      issue(pis_pkg::PIS_PI_LD, 3'h3, a, d);
      `CHK("pi ld fault", 1'h0, resp.align_fault)
      `CHK("pi ld lat", (k > 56) ? 2 : 1, lat)
    end
    $display("test pi align done");
    stop_test();
  end
endmodule

`default_nettype wire
